// ### design/icm_top.sv
// Interrupt cause and enable registers behind an AXI4-Lite slave.
// Operation
// - Writing 1 to a cause-force bit sets that cause like its event.
// - Cause-force bits written 0 leave causes unchanged.
// - A forced cause shows as set in the cause read register.
// - Host interrupt asserts while any cause bit and its enable are set.
// - Reading the enable set/read register returns the enable vector.
// - Enable bit 1 enables its cause, 0 disables it.
// - Writing 1 to an enable set/read bit sets that enable.
// - Enable set/read bits written 0 stay unchanged.
// - Tx descriptor written back is bit 0, link change bit 2.
// - Rx sequence error is bit 3, descriptor minimum threshold bit 4.
// - Receiver overrun is bit 6, raised on receive FIFO overrun.
// - Rx descriptor write-back is bit 7, raised per write-back.
// - Management access complete is bit 9, config ordered sets bit 10.
// - General-purpose pin causes occupy bits 11 to 14 in pin order.
// - Management event is bit 18, other-media energy detect bit 20.
// - Packet buffer fatal errors: receive bit 22, transmit bit 23.
// - Descriptor handler fatal errors: receive bit 24, transmit 25.
// - Software watchdog timeout is bit 26, Tx DMA desync bit 28.
// - Writing 1 to an enable clear bit clears that enable.
// - Reading the enable clear register returns the enable vector.
`timescale 1ns/1ps

module icm_top (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  // Register bus
  input  wire icm_pkg::icm_axi_req_t         axi_req_i,
  output icm_pkg::icm_axi_rsp_t              axi_rsp_o,
  // Hardware cause events, one-cycle pulses from on-chip logic
  input  wire logic [icm_pkg::ICM_DATA_W-1:0] hw_cause_i,
  // Host interrupt
  output logic                               host_irq_o
);
  import icm_pkg::*;

  icm_state_t s_q;
  icm_state_t s_d;

  // Word-aligned decode; the two low address bits are ignored.
  function automatic icm_reg_t icm_decode(
    input logic [ICM_ADDR_W-1:0] addr
  );
    icm_reg_t r;
    r = ICM_REG_NONE;
    if (addr[ICM_ADDR_W-1:2] == ICM_OFS_CAUSE_READ[ICM_ADDR_W-1:2]) begin
      r = ICM_REG_CAUSE_READ;
    end else if (addr[ICM_ADDR_W-1:2] ==
                 ICM_OFS_CAUSE_FORCE[ICM_ADDR_W-1:2]) begin
      r = ICM_REG_CAUSE_FORCE;
    end else if (addr[ICM_ADDR_W-1:2] ==
                 ICM_OFS_ENABLE_SET[ICM_ADDR_W-1:2]) begin
      r = ICM_REG_ENABLE_SET;
    end else if (addr[ICM_ADDR_W-1:2] ==
                 ICM_OFS_ENABLE_CLR[ICM_ADDR_W-1:2]) begin
      r = ICM_REG_ENABLE_CLR;
    end
    return r;
  endfunction

  // Byte strobes widened to a bit mask, so partial writes touch only
  // the addressed lanes.
  function automatic logic [ICM_DATA_W-1:0] icm_strb_bits(
    input logic [ICM_STRB_W-1:0] strb
  );
    logic [ICM_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < ICM_STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  icm_reg_t              wr_reg;
  icm_reg_t              rd_reg;
  logic [ICM_DATA_W-1:0] wr_bits;
  logic [ICM_DATA_W-1:0] force_bits;
  logic [ICM_DATA_W-1:0] ack_bits;
  logic [ICM_DATA_W-1:0] set_bits;
  logic [ICM_DATA_W-1:0] clr_bits;
  logic [ICM_DATA_W-1:0] rd_value;
  logic                  do_write;

  always_comb begin
    s_d        = s_q;
    wr_reg     = icm_decode(s_q.aw_addr);
    rd_reg     = icm_decode(axi_req_i.araddr);
    wr_bits    = s_q.w_data & icm_strb_bits(s_q.w_strb);
    force_bits = '0;
    ack_bits   = '0;
    set_bits   = '0;
    clr_bits   = '0;
    rd_value   = '0;

    // Write channels are accepted independently and in either order.
    if (s_q.rsp.bvalid && axi_req_i.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (axi_req_i.awvalid && s_q.rsp.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s_q.rsp.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = axi_req_i.wdata;
      s_d.w_strb = axi_req_i.wstrb;
    end

    do_write = s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid;
    if (do_write) begin
      s_d.aw_held    = 1'b0;
      s_d.w_held     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = ICM_RESP_OKAY;
      case (wr_reg)
        ICM_REG_CAUSE_READ: begin
          ack_bits = wr_bits;
        end
        ICM_REG_CAUSE_FORCE: begin
          force_bits = wr_bits;
        end
        ICM_REG_ENABLE_SET: begin
          set_bits = wr_bits;
        end
        ICM_REG_ENABLE_CLR: begin
          clr_bits = wr_bits;
        end
        default: begin
          s_d.rsp.bresp = ICM_RESP_SLVERR;
        end
      endcase
    end

    // A hardware or forced set in the same cycle as an acknowledge wins.
    s_d.cause = ((s_q.cause & ~ack_bits) | hw_cause_i | force_bits)
                & ICM_IMPL_MASK;
    s_d.enable = ((s_q.enable | set_bits) & ~clr_bits)
                 & ICM_IMPL_MASK;
    // Computed from the next values so the interrupt flop moves on the
    // same edge as the cause and enable flops.
    s_d.irq = |(s_d.cause & s_d.enable);

    s_d.rsp.awready = !s_d.aw_held && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.w_held && !s_d.rsp.bvalid;

    // Read channel: one read in flight, answered from current state.
    case (rd_reg)
      ICM_REG_CAUSE_READ: begin
        rd_value = s_q.cause;
      end
      ICM_REG_ENABLE_SET: begin
        rd_value = s_q.enable;
      end
      ICM_REG_ENABLE_CLR: begin
        rd_value = s_q.enable;
      end
      default: begin
        rd_value = '0;
      end
    endcase
    if (s_q.rsp.rvalid && axi_req_i.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = rd_value & ICM_IMPL_MASK;
      s_d.rsp.rresp  = (rd_reg == ICM_REG_NONE) ? ICM_RESP_SLVERR
                                                : ICM_RESP_OKAY;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q        <= '0;
      s_q.cause  <= ICM_CAUSE_RESET;
      s_q.enable <= ICM_ENABLE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp_o  = s_q.rsp;
  assign host_irq_o = s_q.irq;

endmodule

// ### design/icm_pkg.sv
// Register map, cause bit positions and bus carriers of the interrupt unit.
package icm_pkg;

  localparam int ICM_ADDR_W = 8;
  localparam int ICM_DATA_W = 32;
  localparam int ICM_STRB_W = ICM_DATA_W / 8;

  // Register byte offsets.
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_CAUSE_READ  = 8'hc0;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_CAUSE_FORCE = 8'hc8;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_ENABLE_SET  = 8'hd0;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFS_ENABLE_CLR  = 8'hd8;

  // Cause bit positions, shared by every cause and enable register.
  localparam int ICM_BIT_TX_DESC_WB      = 0;
  localparam int ICM_BIT_LINK_CHANGE     = 2;
  localparam int ICM_BIT_RX_SEQ_ERR      = 3;
  localparam int ICM_BIT_RX_DESC_MIN     = 4;
  localparam int ICM_BIT_RX_OVERRUN      = 6;
  localparam int ICM_BIT_RX_DESC_WB      = 7;
  localparam int ICM_BIT_MGMT_ACCESS     = 9;
  localparam int ICM_BIT_RX_CFG_SETS     = 10;
  localparam int ICM_BIT_GP_PIN0         = 11;
  localparam int ICM_GP_PINS             = 4;
  localparam int ICM_BIT_MGMT_EVENT      = 18;
  localparam int ICM_BIT_OTHER_MEDIA     = 20;
  localparam int ICM_BIT_RX_PKTBUF_FATAL = 22;
  localparam int ICM_BIT_TX_PKTBUF_FATAL = 23;
  localparam int ICM_BIT_RX_DESC_FATAL   = 24;
  localparam int ICM_BIT_TX_DESC_FATAL   = 25;
  localparam int ICM_BIT_SW_WATCHDOG     = 26;
  localparam int ICM_BIT_TX_DMA_DESYNC   = 28;

  // Implemented cause positions; every other bit is reserved.
  localparam logic [ICM_DATA_W-1:0] ICM_IMPL_MASK =
      (32'h1 << ICM_BIT_TX_DESC_WB)      | (32'h1 << ICM_BIT_LINK_CHANGE) |
      (32'h1 << ICM_BIT_RX_SEQ_ERR)      | (32'h1 << ICM_BIT_RX_DESC_MIN) |
      (32'h1 << ICM_BIT_RX_OVERRUN)      | (32'h1 << ICM_BIT_RX_DESC_WB)  |
      (32'h1 << ICM_BIT_MGMT_ACCESS)     | (32'h1 << ICM_BIT_RX_CFG_SETS) |
      (((32'h1 << ICM_GP_PINS) - 32'h1) << ICM_BIT_GP_PIN0) |
      (32'h1 << ICM_BIT_MGMT_EVENT)      |
      (32'h1 << ICM_BIT_OTHER_MEDIA)     |
      (32'h1 << ICM_BIT_RX_PKTBUF_FATAL) |
      (32'h1 << ICM_BIT_TX_PKTBUF_FATAL) |
      (32'h1 << ICM_BIT_RX_DESC_FATAL)   |
      (32'h1 << ICM_BIT_TX_DESC_FATAL)   |
      (32'h1 << ICM_BIT_SW_WATCHDOG)     |
      (32'h1 << ICM_BIT_TX_DMA_DESYNC);

  // Reset values.
  localparam logic [ICM_DATA_W-1:0] ICM_CAUSE_RESET  = 32'h0;
  localparam logic [ICM_DATA_W-1:0] ICM_ENABLE_RESET = 32'h0;

  // Bus response codes.
  localparam logic [1:0] ICM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ICM_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ICM_REG_NONE,
    ICM_REG_CAUSE_READ,
    ICM_REG_CAUSE_FORCE,
    ICM_REG_ENABLE_SET,
    ICM_REG_ENABLE_CLR
  } icm_reg_t;

  typedef struct packed {
    logic                  awvalid;
    logic [ICM_ADDR_W-1:0] awaddr;
    logic [2:0]            awprot;
    logic                  wvalid;
    logic [ICM_DATA_W-1:0] wdata;
    logic [ICM_STRB_W-1:0] wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [ICM_ADDR_W-1:0] araddr;
    logic [2:0]            arprot;
    logic                  rready;
  } icm_axi_req_t;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [ICM_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } icm_axi_rsp_t;

  typedef struct packed {
    icm_axi_rsp_t          rsp;
    logic                  aw_held;
    logic [ICM_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [ICM_DATA_W-1:0] w_data;
    logic [ICM_STRB_W-1:0] w_strb;
    logic [ICM_DATA_W-1:0] cause;
    logic [ICM_DATA_W-1:0] enable;
    logic                  irq;
  } icm_state_t;

endpackage

// ### sim/icm_properties.sv
// Port-level properties of the interrupt cause and enable unit.
`timescale 1ns/1ps
module icm_properties
  import icm_pkg::*;
(
  // Clock and reset
  input wire logic                           clock_i,
  input wire logic                           rstn_i,
  // Watched ports
  input wire icm_pkg::icm_axi_req_t          axi_req_i,
  input wire icm_pkg::icm_axi_rsp_t          axi_rsp_o,
  input wire logic [icm_pkg::ICM_DATA_W-1:0] hw_cause_i,
  input wire logic                           host_irq_o
);
  // Short aliases keep every property within two lines.
  icm_axi_req_t q;
  icm_axi_rsp_t s;
  assign q = axi_req_i;
  assign s = axi_rsp_o;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  property p_rd_lat; q.arvalid && s.arready |=> s.rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_rd_hold; s.rvalid && !q.rready |=> $stable(s.rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_wr_lat; q.awvalid && s.awready && q.wvalid && s.wready
    |-> ##[1:2] s.bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write late");
  property p_rsvd; s.rvalid |-> (s.rdata & ~ICM_IMPL_MASK) == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  // An interrupt may only rise from a cause event or a completed write.
  property p_irq_up; $rose(host_irq_o)
    |-> ($past(hw_cause_i) & ICM_IMPL_MASK) != '0 || $rose(s.bvalid); endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose");
  property p_irq_dn; $fell(host_irq_o) |-> $rose(s.bvalid); endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell");
  property p_frd; $rose(s.rvalid) && $past(q.araddr) == ICM_OFS_CAUSE_FORCE
    |-> s.rdata == '0; endproperty
  a_frd: assert property (p_frd) else $error("force read nonzero");
  property p_unmap; $rose(s.rvalid) && $past(q.araddr) == 8'hcc
    |-> s.rresp == ICM_RESP_SLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("no slverr");
endmodule
bind icm_top icm_properties u_props (.clock_i(clock_i), .rstn_i(rstn_i),
  .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .hw_cause_i(hw_cause_i),
  .host_irq_o(host_irq_o));

// ### sim/testbench.sv
// Directed and random bench for the interrupt cause and enable registers.
`timescale 1ns/1ps
module testbench;
  import icm_pkg::*;
  localparam logic [31:0] IMPL = 32'h17d47edd;
  logic         clock_i = 1'b0;
  logic         rstn_i = 1'b0;
  icm_axi_req_t req = '0;
  icm_axi_rsp_t rsp;
  logic [31:0]  hw = '0;
  logic         irq;
  logic [31:0]  cause = '0;
  logic [31:0]  en = '0;
  logic [7:0]   ads [5] = '{8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'hcc};
  int           n_mismatch = 0;
  int           total_checks = 0;
  int           cyc = 0;
  icm_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .axi_req_i(req),
               .axi_rsp_o(rsp), .hw_cause_i(hw), .host_irq_o(irq));
  always #12.5 clock_i = ~clock_i;
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] resp(input logic [7:0] ad);
    return {30'h0, ad == 8'hcc ? ICM_RESP_SLVERR : ICM_RESP_OKAY};
  endfunction
  task automatic irq_ok();
    chk({31'h0, irq}, {31'h0, |(cause & en)});
  endtask
  // Address and data are released independently as each is taken. The
  // cause event h meets the register update, so set against clear is hit.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] sb, input logic [31:0] h);
    logic        aw;
    logic        w;
    logic [31:0] m;
    aw = 1'b0;
    w = 1'b0;
    m = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
    @(posedge clock_i);
    req.awvalid <= 1'b1;
    req.awaddr  <= ad;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= sb;
    req.bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock_i);
      if (rsp.awready && !aw) req.awvalid <= 1'b0;
      if (rsp.wready && !w) req.wvalid <= 1'b0;
      aw = aw | rsp.awready;
      w = w | rsp.wready;
    end
    hw <= h;
    @(posedge clock_i);
    hw <= '0;
    while (!rsp.bvalid) @(posedge clock_i);
    req.bready <= 1'b0;
    chk({30'h0, rsp.bresp}, resp(ad));
    case (ad)
      8'hc0: cause = cause & ~(d & m);
      8'hc8: cause = cause | (d & m & IMPL);
      8'hd0: en = en | (d & m & IMPL);
      8'hd8: en = en & ~(d & m);
      default: ;
    endcase
    cause = cause | (h & IMPL);
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clock_i);
    req.arvalid <= 1'b1;
    req.araddr  <= ad;
    req.rready  <= 1'b1;
    do @(posedge clock_i); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge clock_i); while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk({30'h0, rsp.rresp}, resp(ad));
    chk(rsp.rdata, ad == 8'hc0 ? cause : ad[4] ? en : '0);
  endtask
  // A cause event lasts one cycle; the wait lets the interrupt settle.
  task automatic pulse(input logic [31:0] d);
    @(posedge clock_i);
    hw <= d;
    @(posedge clock_i);
    hw <= '0;
    cause = cause | (d & IMPL);
    @(posedge clock_i);
  endtask
  initial begin
    void'($urandom(32'h3a13));
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(8'hd0);
    for (int i = 0; i < 32; i++) begin
      wr(8'hc8, 32'h1 << i, 4'hf, 32'h0);
      rd(8'hc0);
      irq_ok();
      wr(8'hd0, 32'h1 << i, 4'hf, 32'h0);
      irq_ok();
      rd(8'hd8);
      wr(8'hd8, 32'h1 << i, 4'hf, 32'h0);
      irq_ok();
      wr(8'hc0, 32'h1 << i, 4'hf, 32'h0);
      pulse(32'h1 << i);
      rd(8'hc0);
      wr(8'hc0, 32'hffffffff, 4'hf, 32'h1 << i);
      rd(8'hc0);
      wr(8'hc0, 32'hffffffff, 4'hf, 32'h0);
    end
    repeat (150) begin
      wr(ads[$urandom_range(4)], $urandom, 4'($urandom),
         $urandom & $urandom);
      irq_ok();
      pulse($urandom & $urandom);
      irq_ok();
      rd(ads[$urandom_range(4)]);
    end
    @(posedge clock_i);
    rstn_i <= 1'b0;
    cause = '0;
    en = '0;
    repeat (3) @(posedge clock_i);
    irq_ok();
    chk({29'h0, rsp.awready, rsp.wready, rsp.arready}, 32'h0);
    rstn_i <= 1'b1;
    rd(8'hd0);
    irq_ok();
    print_verdict();
  end
endmodule
